// ===== logic/hmo_op_commands.v
// Contract
// - alarm word: warning b0, critical b1, rate b2, burnout b3, rest zero
// - reads answer single address or contiguous range in one response
// - command code in frame selects one of eight operation commands
// - software reset accepted at every level, runs power-up init
// - software reset clears latched alarms and returns to operation level
// - restart-effective parameters keep old operating value until reset
// - parameter init restores defaults except communications settings
// - restored defaults govern operation only after power-on reset
// - stop accepted only at operation or adjustment levels; goes to initial setting
// - initial and communications settings writable only while stopped
// - once stopped, stays stopped until power-on reset
// - level key held one second while stopped forces power-on reset
// - alarms latch and do not clear on their own
// - latch cancel clears alarm only when measurement below threshold
// - registration start flashes indicator; lit once reference registered
// - device detects stabilization and stores resistance as reference
// - registration cancel only while flashing; aborts, indicator unlit
// - log one entry per logging cycle, default 100 x 10 calc cycles
// - calculation cycle defaults to 100 seconds
// - log refresh start and stop commands control logging
// - reads allowed in any state without side effects
`timescale 1ns/1ns
`include "hmo_regs.vh"
module hmo_op_commands #(
    parameter KEY_HOLD_CYC = `HMO_KEY_HOLD_CYC
) (
    input  wire        ref_clk_i,     // device clock
    input  wire        resetn_i,      // sync reset, active low
    input  wire        clk_en_i,      // freezes all state while low
    input  wire        cmd_valid_i,   // operation command strobe
    input  wire [2:0]  cmd_code_i,    // operation command code
    input  wire        rd_valid_i,    // variable read request
    input  wire [15:0] rd_addr_i,     // first address
    input  wire [3:0]  rd_count_i,    // words minus one
    input  wire        wr_valid_i,    // setting write strobe
    input  wire [15:0] wr_addr_i,     // setting address
    input  wire [15:0] wr_data_i,     // setting data
    input  wire        key_level_i,   // level key pin, active high
    input  wire [3:0]  alarm_cond_i,  // alarm above threshold, per bit
    input  wire        stable_i,      // heater stabilized
    input  wire        calc_tick_i,   // one calculation cycle done
    input  wire [15:0] meas_res_i,    // measured resistance
    output reg         rd_valid_o,    // read data word valid
    output reg  [15:0] rd_data_o,     // read data word
    output reg         rd_last_o,     // last word of a range
    output reg         wr_ack_o,      // write accepted
    output reg         cmd_ack_o,     // command accepted
    output reg  [15:0] alarm_flags_o, // latched alarms
    output reg  [2:0]  op_level_o,    // operating level
    output reg         measuring_o,   // measurement running
    output reg         rdy_flash_o,   // registration indicator flashing
    output reg         rdy_lit_o,     // registration indicator lit
    output reg         log_strobe_o,  // one log entry recorded
    output reg  [15:0] log_rate_o,    // logged change rate
    output reg  [15:0] calc_cycle_o   // active calculation cycle, s
);
    reg [3:0]  alarms;
    reg [2:0]  level;
    reg        stopped;
    reg        reg_busy;
    reg        reg_done;
    reg        log_on;
    reg [15:0] ref_res;
    reg [15:0] calc_act;
    reg [15:0] calc_pend;
    reg [15:0] init_set_act;
    reg [15:0] init_set_pend;
    reg [15:0] comm_set;
    reg [15:0] log_mult;
    reg [15:0] base_cnt;
    reg [15:0] mult_cnt;
    reg [31:0] key_cnt;
    reg [2:0]  key_sync;
    reg        key_lvl;
    reg        rd_busy;
    reg [15:0] rd_ptr;
    reg [3:0]  rd_left;
    reg [15:0] next_rd_word;
    reg        por;
    wire       cmd_stop_ok;

    assign cmd_stop_ok = (level == `HMO_LVL_OPERATION) || (level == `HMO_LVL_ADJ_COM)
                         || (level == `HMO_LVL_ADJ_PWR) || (level == `HMO_LVL_ADJ_TMP);

    // read mux: no state changes from reads
    always @* begin
        case (rd_ptr)
            `HMO_ADDR_ALARM_FLAGS: next_rd_word = {12'h000, alarms};
            `HMO_ADDR_OP_LEVEL:    next_rd_word = {13'h0000, level};
            `HMO_ADDR_REG_STATE:   next_rd_word = {14'h0000, reg_done, reg_busy};
            `HMO_ADDR_LOG_COUNT:   next_rd_word = mult_cnt;
            `HMO_ADDR_REF_RES:     next_rd_word = ref_res;
            `HMO_ADDR_CALC_ACT:    next_rd_word = calc_act;
            `HMO_ADDR_CALC_PEND:   next_rd_word = calc_pend;
            `HMO_ADDR_COMM_SET:    next_rd_word = comm_set;
            `HMO_ADDR_INIT_SET:    next_rd_word = init_set_pend;
            default:               next_rd_word = 16'h0000;
        endcase
    end

    // level key synchroniser: change counts when stages 2 and 3 agree
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            key_sync <= 3'h0;
            key_lvl  <= 1'b0;
        end else if (clk_en_i) begin
            key_sync <= {key_sync[1:0], key_level_i};
            if (key_sync[1] == key_sync[2])
                key_lvl <= key_sync[2];
        end
    end

    // key hold counter while stopped
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            key_cnt <= 32'h0;
        end else if (clk_en_i) begin
            // cleared by power-on reset only while enabled, so a low enable freezes it
            if (por)
                key_cnt <= 32'h0;
            else if (stopped && key_lvl && key_cnt < KEY_HOLD_CYC)
                key_cnt <= key_cnt + 32'h1;
            else if (!key_lvl)
                key_cnt <= 32'h0;
        end
    end

    // power-on reset request: software reset command or key hold
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            por <= 1'b0;
        end else if (clk_en_i) begin
            por <= (cmd_valid_i && cmd_code_i == `HMO_CMD_SW_RESET)
                   || (stopped && key_cnt == KEY_HOLD_CYC - 1);
        end
    end

    // non-volatile settings: survive power-on reset
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            calc_pend     <= `HMO_CALC_CYCLE_DEF;
            init_set_pend <= `HMO_INIT_SET_DEF;
            comm_set      <= 16'h0000;
            wr_ack_o      <= 1'b0;
        end else if (clk_en_i) begin
            wr_ack_o <= 1'b0;
            if (cmd_valid_i && cmd_code_i == `HMO_CMD_PARAM_INIT) begin
                calc_pend     <= `HMO_CALC_CYCLE_DEF;
                init_set_pend <= `HMO_INIT_SET_DEF;
            end else if (wr_valid_i) begin
                case (wr_addr_i)
                    `HMO_ADDR_CALC_PEND: begin
                        calc_pend <= wr_data_i;
                        wr_ack_o  <= 1'b1;
                    end
                    `HMO_ADDR_INIT_SET: if (stopped) begin
                        init_set_pend <= wr_data_i;
                        wr_ack_o      <= 1'b1;
                    end
                    `HMO_ADDR_COMM_SET: if (stopped) begin
                        comm_set <= wr_data_i;
                        wr_ack_o <= 1'b1;
                    end
                    default: wr_ack_o <= 1'b0;
                endcase
            end
        end
    end

    // operating state, cleared by reset pin; power-on reset spares ref_res and reg_done
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            alarms       <= 4'h0;
            level        <= `HMO_LVL_OPERATION;
            stopped      <= 1'b0;
            reg_busy     <= 1'b0;
            reg_done     <= 1'b0;
            log_on       <= 1'b0;
            ref_res      <= 16'h0000;
            calc_act     <= `HMO_CALC_CYCLE_DEF;
            init_set_act <= `HMO_INIT_SET_DEF;
            log_mult     <= `HMO_LOG_MULT_DEF;
            base_cnt     <= 16'h0000;
            mult_cnt     <= 16'h0000;
            cmd_ack_o    <= 1'b0;
            log_strobe_o <= 1'b0;
            log_rate_o   <= 16'h0000;
        end else if (clk_en_i) begin
            cmd_ack_o    <= 1'b0;
            log_strobe_o <= 1'b0;
            if (por) begin
                alarms       <= 4'h0;
                level        <= `HMO_LVL_OPERATION;
                stopped      <= 1'b0;
                reg_busy     <= 1'b0;
                log_on       <= 1'b0;
                base_cnt     <= 16'h0000;
                mult_cnt     <= 16'h0000;
                calc_act     <= calc_pend;
                init_set_act <= init_set_pend;
            end else begin
                alarms <= alarms | alarm_cond_i;
                if (cmd_valid_i) begin
                    case (cmd_code_i)
                        `HMO_CMD_SW_RESET: cmd_ack_o <= 1'b1;
                        `HMO_CMD_PARAM_INIT: cmd_ack_o <= 1'b1;
                        `HMO_CMD_OP_STOP: if (cmd_stop_ok) begin
                            level     <= `HMO_LVL_INIT_SET;
                            stopped   <= 1'b1;
                            cmd_ack_o <= 1'b1;
                        end
                        `HMO_CMD_ALARM_CLR: begin
                            alarms    <= alarm_cond_i;
                            cmd_ack_o <= 1'b1;
                        end
                        `HMO_CMD_REG_START: if (!reg_busy) begin
                            reg_busy  <= 1'b1;
                            reg_done  <= 1'b0;
                            cmd_ack_o <= 1'b1;
                        end
                        `HMO_CMD_REG_CANCEL: if (reg_busy) begin
                            reg_busy  <= 1'b0;
                            reg_done  <= 1'b0;
                            cmd_ack_o <= 1'b1;
                        end
                        `HMO_CMD_LOG_START: begin
                            log_on    <= 1'b1;
                            cmd_ack_o <= 1'b1;
                        end
                        `HMO_CMD_LOG_STOP: begin
                            log_on    <= 1'b0;
                            cmd_ack_o <= 1'b1;
                        end
                        default: cmd_ack_o <= 1'b0;
                    endcase
                end else if (reg_busy && stable_i && !stopped) begin
                    ref_res  <= meas_res_i;
                    reg_busy <= 1'b0;
                    reg_done <= 1'b1;
                end
                if (log_on && !stopped && stable_i && calc_tick_i) begin
                    if (base_cnt == `HMO_LOG_BASE - 16'h1) begin
                        base_cnt <= 16'h0000;
                        if (mult_cnt == log_mult - 16'h1) begin
                            mult_cnt     <= 16'h0000;
                            log_strobe_o <= 1'b1;
                            log_rate_o   <= meas_res_i - ref_res;
                        end else begin
                            mult_cnt <= mult_cnt + 16'h1;
                        end
                    end else begin
                        base_cnt <= base_cnt + 16'h1;
                    end
                end
            end
        end
    end

    // register reads, single word or range
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rd_busy    <= 1'b0;
            rd_ptr     <= 16'h0000;
            rd_left    <= 4'h0;
            rd_valid_o <= 1'b0;
            rd_data_o  <= 16'h0000;
            rd_last_o  <= 1'b0;
        end else if (clk_en_i) begin
            rd_valid_o <= 1'b0;
            rd_last_o  <= 1'b0;
            if (rd_busy) begin
                rd_valid_o <= 1'b1;
                rd_data_o  <= next_rd_word;
                rd_last_o  <= (rd_left == 4'h0);
                rd_ptr     <= rd_ptr + 16'h1;
                rd_left    <= rd_left - 4'h1;
                rd_busy    <= (rd_left != 4'h0);
            end else if (rd_valid_i) begin
                rd_busy <= 1'b1;
                rd_ptr  <= rd_addr_i;
                rd_left <= rd_count_i;
            end
        end
    end

    // mirrored outputs
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            alarm_flags_o <= 16'h0000;
            op_level_o    <= `HMO_LVL_OPERATION;
            measuring_o   <= 1'b0;
            rdy_flash_o   <= 1'b0;
            rdy_lit_o     <= 1'b0;
            calc_cycle_o  <= `HMO_CALC_CYCLE_DEF;
        end else if (clk_en_i) begin
            alarm_flags_o <= {12'h000, alarms};
            op_level_o    <= level;
            measuring_o   <= !stopped;
            rdy_flash_o   <= reg_busy;
            rdy_lit_o     <= reg_done && !reg_busy;
            calc_cycle_o  <= calc_act;
        end
    end
endmodule

// ===== logic/hmo_regs.vh
`ifndef HMO_REGS_VH
`define HMO_REGS_VH
// variable area addresses
`define HMO_ADDR_ALARM_FLAGS 16'h101d
`define HMO_ADDR_OP_LEVEL    16'h1000
`define HMO_ADDR_REG_STATE   16'h1001
`define HMO_ADDR_LOG_COUNT   16'h1002
`define HMO_ADDR_REF_RES     16'h1003
`define HMO_ADDR_CALC_ACT    16'h1004
`define HMO_ADDR_CALC_PEND   16'h1005
`define HMO_ADDR_COMM_SET    16'h1006
`define HMO_ADDR_INIT_SET    16'h1007
// alarm bit positions
`define HMO_AL_WARN   0
`define HMO_AL_CRIT   1
`define HMO_AL_RATE   2
`define HMO_AL_BURN   3
// operation command codes
`define HMO_CMD_SW_RESET   3'h0
`define HMO_CMD_PARAM_INIT 3'h1
`define HMO_CMD_OP_STOP    3'h2
`define HMO_CMD_ALARM_CLR  3'h3
`define HMO_CMD_REG_START  3'h4
`define HMO_CMD_REG_CANCEL 3'h5
`define HMO_CMD_LOG_START  3'h6
`define HMO_CMD_LOG_STOP   3'h7
// operating levels
`define HMO_LVL_OPERATION 3'h0
`define HMO_LVL_ADJ_COM   3'h1
`define HMO_LVL_ADJ_PWR   3'h2
`define HMO_LVL_ADJ_TMP   3'h3
`define HMO_LVL_INIT_SET  3'h4
`define HMO_LVL_COMM1     3'h5
`define HMO_LVL_COMM2     3'h6
// defaults
`define HMO_CALC_CYCLE_DEF 16'h0064
`define HMO_LOG_MULT_DEF   16'h0064
`define HMO_LOG_BASE       16'h000a
`define HMO_INIT_SET_DEF   16'h0000
// timing: key hold 1 s at 100 MHz
`define HMO_KEY_HOLD_MS    1000
`define HMO_CLK_KHZ        100000
`define HMO_KEY_HOLD_CYC   (`HMO_KEY_HOLD_MS * `HMO_CLK_KHZ)
`endif

// ===== tb/hmo_checker.sv
`timescale 1ns/1ns
module hmo_checker (
    input wire        ref_clk_i,     // device clock
    input wire        resetn_i,      // sync reset, active low
    input wire        clk_en_i,      // clock enable
    input wire        cmd_valid_i,   // command strobe
    input wire [2:0]  cmd_code_i,    // command code
    input wire        rd_valid_i,    // read request
    input wire [3:0]  rd_count_i,    // words minus one
    input wire        rd_valid_o,    // read word valid
    input wire        rd_last_o,     // last read word
    input wire        cmd_ack_o,     // command accepted
    input wire [15:0] alarm_flags_o, // latched alarms
    input wire [2:0]  op_level_o,    // operating level
    input wire        measuring_o,   // measurement running
    input wire        rdy_flash_o,   // indicator flashing
    input wire        rdy_lit_o      // indicator lit
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    wire go = cmd_valid_i && clk_en_i;
    a_alarm_upper: assert property (alarm_flags_o[15:4] == 12'h000)
        else $error("alarm upper bits set");
    a_alarm_latch: assert property (!cmd_valid_i && !$past(cmd_valid_i) && !$past(cmd_valid_i, 2)
        && !$past(cmd_valid_i, 3) && op_level_o != 3'h4
        |=> (alarm_flags_o[3:0] & $past(alarm_flags_o[3:0])) == $past(alarm_flags_o[3:0]))
        else $error("latched alarm dropped");
    a_stop_walk: assert property (go && cmd_code_i == 3'h2 && op_level_o <= 3'h3
        |=> cmd_ack_o ##1 (op_level_o == 3'h4 && !measuring_o))
        else $error("stop not carried out");
    a_stop_refused: assert property (go && cmd_code_i == 3'h2 && op_level_o == 3'h4 |=> !cmd_ack_o)
        else $error("stop acked while stopped");
    a_stay_stopped: assert property (op_level_o == 3'h4 |-> !measuring_o)
        else $error("measuring while stopped");
    a_read_single: assert property (rd_valid_i && rd_count_i == 4'h0 && !rd_valid_o
        && !$past(rd_valid_i) |-> ##2 (rd_valid_o && rd_last_o))
        else $error("single read answer wrong");
    a_read_range: assert property (rd_valid_i && rd_count_i == 4'h3 && !rd_valid_o
        && !$past(rd_valid_i) |-> ##2 (rd_valid_o && !rd_last_o) [*3] ##1 (rd_valid_o && rd_last_o))
        else $error("range read answer wrong");
    a_reg_start: assert property (go && cmd_code_i == 3'h4 && !rdy_flash_o |-> ##[1:2] rdy_flash_o)
        else $error("indicator not flashing");
    a_reg_busy: assert property (go && cmd_code_i == 3'h4 && rdy_flash_o |=> !cmd_ack_o)
        else $error("start acked while flashing");
    a_cancel_idle: assert property (go && cmd_code_i == 3'h5 && !rdy_flash_o |=> !cmd_ack_o)
        else $error("cancel acked while idle");
    a_cancel_off: assert property (go && cmd_code_i == 3'h5 && rdy_flash_o
        |-> ##[1:2] (!rdy_flash_o && !rdy_lit_o))
        else $error("cancel left indicator on");
    a_soft_reset: assert property (go && cmd_code_i == 3'h0
        |-> ##[2:3] (op_level_o == 3'h0 && !rdy_flash_o))
        else $error("soft reset did not restore level");
    c_stop: cover property (go && cmd_code_i == 3'h2 ##1 cmd_ack_o);
    c_range: cover property (rd_valid_o && rd_last_o && $past(rd_valid_o));
    c_reg_done: cover property ($rose(rdy_lit_o));
endmodule
bind hmo_op_commands hmo_checker u_chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .clk_en_i(clk_en_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .rd_valid_i(rd_valid_i), .rd_count_i(rd_count_i), .rd_valid_o(rd_valid_o),
    .rd_last_o(rd_last_o), .cmd_ack_o(cmd_ack_o), .alarm_flags_o(alarm_flags_o),
    .op_level_o(op_level_o), .measuring_o(measuring_o), .rdy_flash_o(rdy_flash_o),
    .rdy_lit_o(rdy_lit_o));

// ===== tb/hmo_host.sv
`timescale 1ns/1ns
module hmo_host (
    input  wire        clk_i,       // device clock
    output reg         cmd_valid_o, // command strobe
    output reg  [2:0]  cmd_code_o,  // command code
    output reg         rd_valid_o,  // read request
    output reg  [15:0] rd_addr_o,   // first address
    output reg  [3:0]  rd_count_o,  // words minus one
    output reg         wr_valid_o,  // write strobe
    output reg  [15:0] wr_addr_o,   // write address
    output reg  [15:0] wr_data_o,   // write data
    input  wire        rd_valid_i,  // read word valid
    input  wire [15:0] rd_data_i,   // read word
    input  wire        rd_last_i,   // last word
    input  wire        wr_ack_i,    // write accepted
    input  wire        cmd_ack_i    // command accepted
);
    initial begin
        {cmd_valid_o, rd_valid_o, wr_valid_o} = 3'h0;
        {cmd_code_o, rd_addr_o, rd_count_o, wr_addr_o, wr_data_o} = 55'h0;
    end
    task send_cmd(input [2:0] code, output ack);
        @(posedge clk_i) #1 {cmd_valid_o, cmd_code_o} = {1'b1, code};
        @(posedge clk_i) #1 cmd_valid_o = 1'b0;
        ack = cmd_ack_i;
    endtask
    task write(input [15:0] addr, input [15:0] data, output ack);
        @(posedge clk_i) #1 {wr_valid_o, wr_addr_o, wr_data_o} = {1'b1, addr, data};
        @(posedge clk_i) #1 wr_valid_o = 1'b0;
        ack = wr_ack_i;
    endtask
    // collects the first word and counts words until the last one
    task read(input [15:0] addr, input [3:0] cnt, output [15:0] first, output [4:0] words);
        integer i;
        words = 5'h00;
        first = 16'hffff;
        @(posedge clk_i) #1 {rd_valid_o, rd_addr_o, rd_count_o} = {1'b1, addr, cnt};
        @(posedge clk_i) #1 rd_valid_o = 1'b0;
        for (i = 0; i < 20; i = i + 1) begin
            if (rd_valid_i === 1'b1 && words == 5'h00)
                first = rd_data_i;
            if (rd_valid_i === 1'b1)
                words = words + 5'h01;
            if (rd_last_i === 1'b1)
                break;
            @(posedge clk_i) #1;
        end
    endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
    reg         ref_clk_i = 1'b0;
    reg         resetn_i  = 1'b0;
    reg         key       = 1'b0;
    reg  [3:0]  alarm_c   = 4'h0;
    reg         stable    = 1'b0;
    reg         tick      = 1'b0;
    reg  [15:0] meas      = 16'h0000;
    wire        cmd_valid, rd_valid, wr_valid, rd_v, rd_last, wr_ack, cmd_ack;
    wire        measuring, flash, lit, log_strobe;
    wire [2:0]  cmd_code, level;
    wire [3:0]  rd_count;
    wire [15:0] rd_addr, wr_addr, wr_data, rd_data, flags, log_rate, calc;
    reg         ack;
    reg  [15:0] first;
    reg  [4:0]  words;
    integer     n_mismatch = 0, samples_checked = 0, n_log = 0, cycles = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    hmo_op_commands #(.KEY_HOLD_CYC(20)) dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .clk_en_i(1'b1), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .rd_valid_i(rd_valid),
        .rd_addr_i(rd_addr), .rd_count_i(rd_count), .wr_valid_i(wr_valid), .wr_addr_i(wr_addr),
        .wr_data_i(wr_data), .key_level_i(key), .alarm_cond_i(alarm_c), .stable_i(stable),
        .calc_tick_i(tick), .meas_res_i(meas), .rd_valid_o(rd_v), .rd_data_o(rd_data),
        .rd_last_o(rd_last), .wr_ack_o(wr_ack), .cmd_ack_o(cmd_ack), .alarm_flags_o(flags),
        .op_level_o(level), .measuring_o(measuring), .rdy_flash_o(flash), .rdy_lit_o(lit),
        .log_strobe_o(log_strobe), .log_rate_o(log_rate), .calc_cycle_o(calc));
    hmo_host host (.clk_i(ref_clk_i), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
        .rd_valid_o(rd_valid), .rd_addr_o(rd_addr), .rd_count_o(rd_count),
        .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_valid_i(rd_v),
        .rd_data_i(rd_data), .rd_last_i(rd_last), .wr_ack_i(wr_ack), .cmd_ack_i(cmd_ack));
    always @(posedge ref_clk_i) begin
        if (log_strobe === 1'b1)
            n_log <= n_log + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end
    task cyc(input integer n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task ticks(input integer n);
        repeat (n) begin
            @(posedge ref_clk_i) #1 tick = 1'b1;
            @(posedge ref_clk_i) #1 tick = 1'b0;
        end
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        cyc(4);
        resetn_i = 1'b1;
        `CHK("level", 3'h0, level)
        `CHK("calc", 16'h0064, calc)
        alarm_c = 4'hf;
        cyc(1);
        alarm_c = 4'h0;
        cyc(2);
        `CHK("flags", 16'h000f, flags)
        alarm_c = 4'h2;
        host.send_cmd(3'h3, ack);
        alarm_c = 4'h0;
        cyc(2);
        `CHK("flags", 16'h0002, flags)
        host.read(16'h101d, 4'h0, first, words);
        `CHK("rd word", 16'h0002, first)
        `CHK("rd count", 5'h01, words)
        host.read(16'h1000, 4'h3, first, words);
        `CHK("rd count", 5'h04, words)
        host.read(16'h2000, 4'h0, first, words);
        `CHK("unmapped", 16'h0000, first)
        host.send_cmd(3'h3, ack);
        cyc(2);
        `CHK("flags", 16'h0000, flags)
        host.write(16'h1007, 16'h0001, ack);
        `CHK("wr run", 1'b0, ack)
        host.write(16'h1005, 16'h0032, ack);
        `CHK("calc", 16'h0064, calc)
        host.send_cmd(3'h2, ack);
        cyc(1);
        `CHK("level", 3'h4, level)
        `CHK("measuring", 1'b0, measuring)
        host.send_cmd(3'h2, ack);
        `CHK("stop ack", 1'b0, ack)
        host.write(16'h1006, 16'h0007, ack);
        `CHK("wr stop", 1'b1, ack)
        cyc(30);
        `CHK("level", 3'h4, level)
        key = 1'b1;
        cyc(40);
        key = 1'b0;
        cyc(4);
        `CHK("level", 3'h0, level)
        `CHK("calc", 16'h0032, calc)
        host.send_cmd(3'h1, ack);
        cyc(2);
        `CHK("calc", 16'h0032, calc)
        alarm_c = 4'h8;
        host.send_cmd(3'h2, ack);
        alarm_c = 4'h0;
        host.send_cmd(3'h0, ack);
        cyc(4);
        `CHK("level", 3'h0, level)
        `CHK("flags", 16'h0000, flags)
        `CHK("calc", 16'h0064, calc)
        host.read(16'h1006, 4'h0, first, words);
        `CHK("comm", 16'h0007, first)
        host.send_cmd(3'h4, ack);
        `CHK("start ack", 1'b1, ack)
        cyc(1);
        `CHK("flash", 1'b1, flash)
        host.send_cmd(3'h4, ack);
        `CHK("start ack", 1'b0, ack)
        host.send_cmd(3'h5, ack);
        cyc(1);
        `CHK("lit", 2'b00, {flash, lit})
        host.send_cmd(3'h5, ack);
        `CHK("cancel ack", 1'b0, ack)
        meas = 16'h0100;
        host.send_cmd(3'h4, ack);
        stable = 1'b1;
        cyc(3);
        `CHK("lit", 2'b01, {flash, lit})
        host.read(16'h1003, 4'h0, first, words);
        `CHK("ref", 16'h0100, first)
        meas = 16'h0105;
        host.send_cmd(3'h6, ack);
        ticks(999);
        `CHK("logs", 0, n_log)
        ticks(1);
        cyc(2);
        `CHK("logs", 1, n_log)
        `CHK("rate", 16'h0005, log_rate)
        host.send_cmd(3'h7, ack);
        ticks(1000);
        cyc(2);
        `CHK("logs", 1, n_log)
        finish_test;
    end
endmodule
